/* File: hid_core.sv */
// Purpose: Iterative truncating divider, four quotient bits per cycle.
// Assumes: Operands stable from load onward; load is a one-cycle pulse.
// Notes: Completes in a fixed eight steps regardless of operand values.
`timescale 1ns/1ps
`default_nettype none
module hid_core
    import hid_pkg::*;
#(
    parameter int WIDTH = 32
)
(
    input wire logic sys_clk,         // System clock
    input wire logic rst_n,           // Synchronous reset, active low
    input wire logic load,            // Take operands this cycle
    input wire hid_oper_t oper,       // Operands and mode
    output logic done,                // One-cycle pulse when result valid
    output hid_result_t result        // Quotient and remainder
);

    // The engine below is written for one 32-bit word only
    if (WIDTH != 32 || WIDTH % HID_STEP_BITS != 0)
    begin : g_width_check
        $error("hid_core: WIDTH must be 32");
    end

    typedef struct packed {
        logic run;
        logic [3:0] steps;
        logic [31:0] rem;
        logic [31:0] quo;
        logic [31:0] dvs;
        logic negQ;
        logic negR;
        logic done;
        hid_result_t result;
    } hid_core_state_t;

    hid_core_state_t st;
    hid_core_state_t next_st;

    function automatic logic [31:0] absVal(input logic [31:0] v, input logic sgn);
        absVal = (sgn && v[31]) ? 32'(-v) : v;
    endfunction

    always_comb
    begin
        logic [32:0] trial;
        logic [31:0] r;
        logic [31:0] q;
        trial = 33'h0_0000_0000;
        r = st.rem;
        q = st.quo;
        next_st = st;
        next_st.done = 1'b0;
        if (load)
        begin
            // Magnitudes are divided and signs restored, giving round toward zero
            next_st.run = 1'b1;
            next_st.steps = HID_CALC_CYCLES;
            next_st.rem = 32'h0000_0000;
            next_st.quo = absVal(oper.dividend, oper.isSigned);
            next_st.dvs = absVal(oper.divisor, oper.isSigned);
            next_st.negQ = oper.isSigned && (oper.dividend[31] ^ oper.divisor[31]);
            next_st.negR = oper.isSigned && oper.dividend[31];
        end
        else if (st.run)
        begin
            next_st.steps = st.steps - 4'h1;
            if (st.steps == 4'h1)
            begin
                next_st.run = 1'b0;
                next_st.done = 1'b1;
            end
        end
        // Restoring division, four quotient bits per step
        if (!load && st.run)
        begin
            r = st.rem;
            q = st.quo;
            for (int i = 0; i < HID_STEP_BITS; i++)
            begin
                trial = {r, q[31]} - {1'b0, st.dvs};
                if (trial[32])
                    r = {r[30:0], q[31]};
                else
                    r = trial[31:0];
                q = {q[30:0], ~trial[32]};
            end
            next_st.rem = r;
            next_st.quo = q;
            if (st.steps == 4'h1)
            begin
                next_st.result.quotient = st.negQ ? 32'(-q) : q;
                next_st.result.remainder = st.negR ? 32'(-r) : r;
            end
        end
        if (!rst_n)
        begin
            next_st = '0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        st <= next_st;
    end

    assign done = st.done;
    assign result = st.result;

endmodule
`default_nettype wire

/* File: hid_pkg.sv */
// Purpose: Shared constants and types for the hardware integer divider.
// Assumes: APB slave with 32-bit data, word-aligned registers.
// Notes: Register offsets are byte addresses.
package hid_pkg;

    localparam logic [11:0] HID_OFF_CTRL = 12'h000;
    localparam logic [11:0] HID_OFF_STAT = 12'h004;
    localparam logic [11:0] HID_OFF_DVD = 12'h008;
    localparam logic [11:0] HID_OFF_DVS = 12'h00C;
    localparam logic [11:0] HID_OFF_QUO = 12'h010;
    localparam logic [11:0] HID_OFF_REM = 12'h014;
    localparam logic [11:0] HID_OFF_MASK = 12'h018;

    localparam int HID_CTRL_START = 0;
    localparam int HID_CTRL_SIGNED = 1;
    localparam int HID_STAT_DONE = 0;
    localparam int HID_STAT_DZ = 1;
    localparam int HID_STAT_BUSY = 2;

    localparam logic [31:0] HID_RST_WORD = 32'h0000_0000;
    localparam logic [1:0] HID_RST_FLAGS = 2'h0;

    // Engine calculation cycles from load to done pulse
    localparam logic [3:0] HID_CALC_CYCLES = 4'h8;
    localparam logic [3:0] HID_CNT_ZERO = 4'h0;
    localparam int HID_STEP_BITS = 4;

    typedef enum logic [0:0] {HID_IDLE, HID_RUN} hid_state_t;

    typedef struct packed {
        logic [31:0] dividend;
        logic [31:0] divisor;
        logic isSigned;
    } hid_oper_t;

    typedef struct packed {
        logic [31:0] quotient;
        logic [31:0] remainder;
    } hid_result_t;

endpackage

/* File: hid_top.sv */
// Purpose: APB-mapped 32-bit signed/unsigned integer divider.
// Assumes: APB3 slave, zero wait states, word-aligned accesses.
// Notes: Divide by zero yields all-ones magnitude quotient; flag marks it.
//
// Operation
// - Operands are 32-bit dividend and divisor, read as signed or unsigned by a control bit.
// - Starting latches the operands into the engine in one clock cycle before calculating.
// - The quotient truncates toward zero, discarding any fraction.
// - A calculation begins only when software writes the start bit, never on its own.
// - The completion flag sets ten clock cycles after the start.
// - A zero divisor during a calculation sets the division-by-zero flag.
`timescale 1ns/1ps
`default_nettype none
module hid_top
    import hid_pkg::*;
(
    input wire logic sys_clk,         // System clock, 20 MHz
    input wire logic rst_n,           // Synchronous reset, active low
    input wire logic psel,            // APB select
    input wire logic penable,         // APB access phase
    input wire logic pwrite,          // APB direction, high for write
    input wire logic [11:0] paddr,    // APB byte address
    input wire logic [31:0] pwdata,   // APB write data
    output logic [31:0] prdata,       // APB read data
    output logic pready,              // APB ready, always high
    output logic pslverr,             // APB error for unmapped address
    output logic irq                  // Level interrupt, unmasked flag set
);

    typedef struct packed {
        hid_state_t fsm;
        logic [31:0] dividend;
        logic [31:0] divisor;
        logic isSigned;
        logic [1:0] flags;
        logic [1:0] mask;
        logic load;
        logic [3:0] elapsed;
        hid_result_t result;
        logic [31:0] rdata;
    } hid_top_state_t;

    hid_top_state_t st;
    hid_top_state_t next_st;

    logic coreDone;
    hid_result_t coreResult;
    hid_oper_t oper;

    logic access;
    logic wrEn;
    logic rdEn;
    logic mapped;

    assign access = psel && penable;
    assign wrEn = access && pwrite;
    assign rdEn = access && !pwrite;
    assign mapped = (paddr == HID_OFF_CTRL) || (paddr == HID_OFF_STAT)
        || (paddr == HID_OFF_DVD) || (paddr == HID_OFF_DVS)
        || (paddr == HID_OFF_QUO) || (paddr == HID_OFF_REM)
        || (paddr == HID_OFF_MASK);

    assign oper.dividend = st.dividend;
    assign oper.divisor = st.divisor;
    assign oper.isSigned = st.isSigned;

    hid_core #(
        .WIDTH(32)
    ) u_core (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .load(st.load),
        .oper(oper),
        .done(coreDone),
        .result(coreResult)
    );

    always_comb
    begin
        logic startReq;
        logic [1:0] setFlags;
        startReq = wrEn && (paddr == HID_OFF_CTRL) && pwdata[HID_CTRL_START];
        setFlags = 2'h0;
        next_st = st;
        next_st.load = 1'b0;
        next_st.rdata = 32'h0000_0000;

        unique case (st.fsm)
            HID_IDLE:
            begin
                if (startReq)
                begin
                    // Load pulse next cycle; engine latches operands then
                    next_st.fsm = HID_RUN;
                    next_st.load = 1'b1;
                    next_st.elapsed = HID_CNT_ZERO;
                    next_st.flags = HID_RST_FLAGS;
                end
            end
            HID_RUN:
            begin
                next_st.elapsed = st.elapsed + 4'h1;
                if (st.divisor == 32'h0000_0000)
                    setFlags[HID_STAT_DZ] = 1'b1;
                if (coreDone)
                begin
                    next_st.fsm = HID_IDLE;
                    next_st.result = coreResult;
                    setFlags[HID_STAT_DONE] = 1'b1;
                end
            end
        endcase

        if (wrEn)
        begin
            // Operands are locked while running so the engine sees stable values
            if (paddr == HID_OFF_CTRL)
                next_st.isSigned = (st.fsm == HID_IDLE) ? pwdata[HID_CTRL_SIGNED] : st.isSigned;
            if (paddr == HID_OFF_DVD && st.fsm == HID_IDLE)
                next_st.dividend = pwdata;
            if (paddr == HID_OFF_DVS && st.fsm == HID_IDLE)
                next_st.divisor = pwdata;
            if (paddr == HID_OFF_STAT && !startReq)
                next_st.flags = next_st.flags & ~pwdata[1:0];
            if (paddr == HID_OFF_MASK)
                next_st.mask = pwdata[1:0];
        end
        // Hardware set wins over a same-cycle software clear
        next_st.flags = next_st.flags | setFlags;

        if (rdEn)
        begin
            unique case (paddr)
                HID_OFF_CTRL: next_st.rdata = {30'h0, st.isSigned, 1'b0};
                HID_OFF_STAT: next_st.rdata = {29'h0, st.fsm == HID_RUN, st.flags};
                HID_OFF_DVD: next_st.rdata = st.dividend;
                HID_OFF_DVS: next_st.rdata = st.divisor;
                HID_OFF_QUO: next_st.rdata = st.result.quotient;
                HID_OFF_REM: next_st.rdata = st.result.remainder;
                HID_OFF_MASK: next_st.rdata = {30'h0, st.mask};
                default: next_st.rdata = 32'h0000_0000;
            endcase
        end

        if (!rst_n)
        begin
            next_st = '0;
            next_st.fsm = HID_IDLE;
            next_st.dividend = HID_RST_WORD;
            next_st.divisor = HID_RST_WORD;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        st <= next_st;
    end

    // Read data is combinational from state so a zero-wait access returns it
    always_comb
    begin
        prdata = 32'h0000_0000;
        if (rdEn)
        begin
            unique case (paddr)
                HID_OFF_CTRL: prdata = {30'h0, st.isSigned, 1'b0};
                HID_OFF_STAT: prdata = {29'h0, st.fsm == HID_RUN, st.flags};
                HID_OFF_DVD: prdata = st.dividend;
                HID_OFF_DVS: prdata = st.divisor;
                HID_OFF_QUO: prdata = st.result.quotient;
                HID_OFF_REM: prdata = st.result.remainder;
                HID_OFF_MASK: prdata = {30'h0, st.mask};
                default: prdata = 32'h0000_0000;
            endcase
        end
    end

    assign pready = 1'b1;
    assign pslverr = access && !mapped;
    assign irq = |(st.flags & st.mask);

endmodule
`default_nettype wire

/* File: hid_top_checker.sv */
// Purpose: Port-level assertions for the integer divider.
// Assumes: Zero-wait APB; start accepted only while idle.
// Notes: Run phase is tracked by a local counter, not by internals.
`timescale 1ns/1ps
`default_nettype none
module hid_top_checker
    import hid_pkg::*;
(
    input wire logic sys_clk,        // Clock
    input wire logic rst_n,          // Reset, active low
    input wire logic psel,           // Select
    input wire logic penable,        // Access phase
    input wire logic pwrite,         // Direction
    input wire logic [11:0] paddr,   // Address
    input wire logic [31:0] pwdata,  // Write data
    input wire logic [31:0] prdata,  // Read data
    input wire logic pready,         // Ready
    input wire logic pslverr,        // Error
    input wire logic irq             // Interrupt
);
    logic [3:0] cnt;
    logic seen;
    logic [1:0] mask;
    wire acc = psel && penable;
    wire mapped = paddr[1:0] == 2'h0 && paddr <= HID_OFF_MASK;
    wire st = acc && pwrite && paddr == HID_OFF_CTRL && pwdata[HID_CTRL_START];
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            cnt <= 4'h0;
            seen <= 1'b0;
            mask <= 2'h0;
        end
        else
        begin
            if (st && cnt == 4'h0)
            begin
                cnt <= 4'h1;
                seen <= 1'b1;
            end
            else if (cnt == 4'hA)
                cnt <= 4'h0;
            else if (cnt != 4'h0)
                cnt <= cnt + 4'h1;
            if (acc && pwrite && paddr == HID_OFF_MASK)
                mask <= pwdata[1:0];
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence statRd;
        acc && !pwrite && paddr == HID_OFF_STAT;
    endsequence
    sequence running;
        cnt inside {[4'h1:4'h9]};
    endsequence
    ready_high_a: assert property (pready) else $error("pready low");
    idle_quiet_a: assert property (!acc |-> prdata == 32'h0 && !pslverr)
        else $error("bus output outside access");
    unmapped_err_a: assert property (acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (acc && mapped |-> !pslverr) else $error("mapped access refused");
    run_flags_a: assert property (statRd and running |-> prdata[2:0] == 3'h4 || prdata[2:0] == 3'h6)
        else $error("status wrong while running");
    no_self_start_a: assert property (statRd and !seen |-> prdata[2:0] == 3'h0)
        else $error("activity without start");
    start_reads0_a: assert property (acc && !pwrite && paddr == HID_OFF_CTRL |-> !prdata[HID_CTRL_START])
        else $error("start bit reads one");
    irq_masked_a: assert property (mask == 2'h0 |-> !irq) else $error("irq while masked");
    irq_flag_a: assert property (statRd and (|(prdata[1:0] & mask)) |-> irq)
        else $error("irq missing for flag");
endmodule
bind hid_top hid_top_checker i_hid_top_checker (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq));
`default_nettype wire

/* File: tb_hid_top.sv */
// Purpose: Register-level regression of the integer divider.
// Assumes: Flag visible from edge start+10, as handed over.
// Notes: Each transfer ends with one idle cycle, so status samples land on exact edges.
`timescale 1ns/1ps
`default_nettype none
module tb_hid_top;
    import hid_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    int bad_count = 0;
    int comparisons = 0;
    logic [31:0] rd;
    logic err;
    logic [32:0] tv [6][5];
    hid_top i_hid_top (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq));
    always #25 sys_clk = ~sys_clk;
    task automatic test_done();
        $display("checks %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 40);
        if (pready !== 1'b1)
        begin
            bad_count++;
            $display("unexpected pready: expected 1, seen %b", pready);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask
    initial
    begin
        #(50 * 3000);
        bad_count++;
        test_done();
    end
    initial
    begin
        // dividend, divisor, signed, quotient, remainder
        tv[0] = '{32'd100, 32'd7, 1, 32'd14, 32'd2};
        tv[1] = '{32'hFFFFFFF9, 32'h2, 1, 32'hFFFFFFFD, 32'hFFFFFFFF};
        tv[2] = '{32'h7, 32'hFFFFFFFE, 1, 32'hFFFFFFFD, 32'h1};
        tv[3] = '{32'hFFFFFFF9, 32'h2, 0, 32'h7FFFFFFC, 32'h1};
        tv[4] = '{32'h5, 32'h0, 0, 32'hFFFFFFFF, 32'h5};
        tv[5] = '{32'h1, 32'h1, 0, 32'h1, 32'h0};
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        rdchk("dividend", HID_OFF_DVD, HID_RST_WORD);
        rdchk("status", HID_OFF_STAT, 32'h0);
        xfer(1'b1, HID_OFF_CTRL, 32'h2);
        repeat (12) @(posedge sys_clk);
        rdchk("status", HID_OFF_STAT, 32'h0);
        xfer(1'b0, 12'h01C, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        $display("reset and decode done");
        for (int i = 0; i < 6; i++)
        begin
            xfer(1'b1, HID_OFF_DVD, tv[i][0][31:0]);
            xfer(1'b1, HID_OFF_DVS, tv[i][1][31:0]);
            xfer(1'b1, HID_OFF_CTRL, {30'h0, tv[i][2][0], 1'b1});
            repeat (6) @(posedge sys_clk);
            rdchk("early status", HID_OFF_STAT, tv[i][1] == 0 ? 32'h6 : 32'h4);
            rdchk("final status", HID_OFF_STAT, tv[i][1] == 0 ? 32'h3 : 32'h1);
            rdchk("quotient", HID_OFF_QUO, tv[i][3][31:0]);
            rdchk("remainder", HID_OFF_REM, tv[i][4][31:0]);
        end
        $display("division table done");
        chk("irq", 32'h0, {31'h0, irq});
        xfer(1'b1, HID_OFF_MASK, 32'h1);
        chk("irq", 32'h1, {31'h0, irq});
        rdchk("mask", HID_OFF_MASK, 32'h1);
        xfer(1'b1, HID_OFF_STAT, 32'h1);
        chk("irq", 32'h0, {31'h0, irq});
        rdchk("status", HID_OFF_STAT, 32'h0);
        $display("interrupt done");
        test_done();
    end
endmodule
`default_nettype wire
